//--- include/ipsrc_consts.vh
// constants for the interrupt priority and source block
// What this block does
// - first priority register, eight bits, reset ones
// - priority bit one high, zero low
// - small package: parallel port bit reads zero
// - second priority register, bit zero resets zero
// - third priority register, two bits, reset ones
// - priority enable selects two-level or single-level
// - reset control holds six reset-cause flags
// - pin edge select: one rising, zero falling
// - selected edge sets flag; enable gates request
// - enabled pin interrupts wake from sleep
// - after wake, vector only if global enable
// - pin one, two priority in third control
// - pin zero always high priority
// - timer zero 8-bit rollover sets flag
// - timer zero 16-bit rollover sets flag
// - timer zero enable and priority bits
// - port b upper change sets port flag
// - entry pushes return address onto stack
// - entry shadows working, status, bank registers
// - single-level needs peripheral enable for peripherals
// - peripheral priorities apply only when enabled
`ifndef IPSRC_CONSTS_VH
`define IPSRC_CONSTS_VH
`define IPSRC_A_PRI1 3'h0
`define IPSRC_A_PRI2 3'h1
`define IPSRC_A_PRI3 3'h2
`define IPSRC_A_RESET_CAUSE_AND_PRIORITY_CONTROL 3'h3
`define IPSRC_A_ICON 3'h4
`define IPSRC_A_ICON2 3'h5
`define IPSRC_A_ICON3 3'h6
`define IPSRC_A_TCTL 3'h7
`define IPSRC_RST_PRI1 8'hff
`define IPSRC_RST_PRI2 8'hc8
`define IPSRC_MSK_PRI2 8'hc9
`define IPSRC_RST_PRI3 8'hc0
`define IPSRC_MSK_PRI3 8'hc0
`define IPSRC_RST_RESET_CAUSE_AND_PRIORITY_CONTROL 8'h3c
`define IPSRC_MSK_RESET_CAUSE_AND_PRIORITY_CONTROL 8'hbf
`define IPSRC_RO_RESET_CAUSE_AND_PRIORITY_CONTROL 8'h0c
`define IPSRC_RST_ICON 8'h00
`define IPSRC_RST_ICON2 8'hf5
`define IPSRC_MSK_ICON2 8'hf5
`define IPSRC_RST_ICON3 8'hc0
`define IPSRC_MSK_ICON3 8'hdb
`define IPSRC_PSP_BIT 7
`define IPSRC_PRIORITY_LEVELS_ENABLE_BIT 7
`define IPSRC_GIE_BIT 7
`define IPSRC_PERIPHERAL_INTERRUPT_ENABLE_BIT 6
`define IPSRC_T0IE_BIT 5
`define IPSRC_P0IE_BIT 4
`define IPSRC_PORT_CHANGE_ENABLE_BIT 3
`define IPSRC_P0IF_BIT 1
`define IPSRC_PORT_CHANGE_FLAG_BIT 0
`define IPSRC_T0IP_BIT 2
`define IPSRC_PORT_CHANGE_PRIORITY_BIT 0
`define IPSRC_P1IP_BIT 6
`define IPSRC_P2IP_BIT 7
`define IPSRC_P1IE_BIT 3
`define IPSRC_P2IE_BIT 4
`define IPSRC_P1IF_BIT 0
`define IPSRC_P2IF_BIT 1
`define IPSRC_T16_BIT 0
`define IPSRC_EDGE0_BIT 7
`define IPSRC_T0IF_BIT 2
`endif

//--- design/ipsrc_top.v
// interrupt priority, pin and timer sources, and entry context save
`timescale 1ns/10ps
`default_nettype none
`include "ipsrc_consts.vh"
module ipsrc_top #(
  parameter PIN28 = 0,
  parameter DATA_W = 8,
  parameter PC_W = 21,
  parameter STK_DEPTH = 31
) (
  // clock and reset
  input wire core_clk,
  input wire rstn,
  // register port
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // external pins
  input wire [2:0] pin_irq,
  input wire [7:4] port_b_pins,
  // peripheral sources, flags already enabled by their owners
  input wire [7:0] periph_req_one,
  input wire [7:0] periph_req_two,
  input wire [7:0] periph_req_three,
  // timer zero tick
  input wire timer_tick,
  // reset cause updates
  input wire [5:0] cause_set,
  input wire [5:0] cause_clr,
  // core side
  input wire sleeping,
  input wire entry_ack,
  input wire fast_return,
  input wire [PC_W-1:0] return_pc,
  input wire [DATA_W-1:0] working_register,
  input wire [DATA_W-1:0] status_in,
  input wire [DATA_W-1:0] bank_select_register,
  output reg irq_high,
  output reg irq_low,
  output reg wake,
  output reg [PC_W-1:0] stack_top,
  output reg [DATA_W-1:0] shadow_working,
  output reg [DATA_W-1:0] shadow_status,
  output reg [DATA_W-1:0] shadow_bank
);
  reg [7:0] pri1_q, pri2_q, pri3_q, reset_cause_and_priority_control_q, icon_q, icon2_q, icon3_q, tctl_q;
  reg [15:0] tmr0_q;
  reg [2:0] pin_s1_q, pin_s2_q, pin_s3_q;
  reg [7:4] rb_s1_q, rb_s2_q, rb_s3_q, rb_last_q;
  // filtered levels: follow stage three once stages two and three agree
  reg [2:0] pin_lvl_q;
  reg [7:4] rb_lvl_q;
  reg hsvc_q, lsvc_q;
  reg [4:0] sp_q;
  reg [PC_W-1:0] stack_mem [0:STK_DEPTH-1];
  wire [7:0] pri1_mask = PIN28 ? 8'h7f : 8'hff;
  wire [2:0] edge_hit;
  wire rb_change;
  wire t0_roll;
  wire priority_levels_enable = reset_cause_and_priority_control_q[`IPSRC_PRIORITY_LEVELS_ENABLE_BIT];
  wire global_interrupt_enable = icon_q[`IPSRC_GIE_BIT];
  wire peripheral_interrupt_enable = icon_q[`IPSRC_PERIPHERAL_INTERRUPT_ENABLE_BIT];
  wire [2:0] pin_en;
  wire [2:0] pin_fl;
  wire [2:0] pin_pri;
  wire p_hi_req, p_lo_req;
  reg core_hi, core_lo, per_hi, per_lo;
  // pins: three stages, change counted when stage two and three agree
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_pin
      assign edge_hit[g] = (pin_s2_q[g] == pin_s3_q[g]) &&
        (pin_s3_q[g] != pin_lvl_q[g]) &&
        (pin_s3_q[g] == icon2_q[`IPSRC_EDGE0_BIT-g]);
    end
  endgenerate
  assign rb_change = |(rb_lvl_q ^ rb_last_q);
  assign t0_roll = timer_tick && (tctl_q[`IPSRC_T16_BIT] ?
    (tmr0_q == 16'hffff) : (tmr0_q[7:0] == 8'hff));
  assign pin_en = {icon3_q[`IPSRC_P2IE_BIT], icon3_q[`IPSRC_P1IE_BIT],
    icon_q[`IPSRC_P0IE_BIT]};
  assign pin_fl = {icon3_q[`IPSRC_P2IF_BIT], icon3_q[`IPSRC_P1IF_BIT],
    icon_q[`IPSRC_P0IF_BIT]};
  assign pin_pri = {icon3_q[`IPSRC_P2IP_BIT], icon3_q[`IPSRC_P1IP_BIT],
    1'b1};
  // peripheral requests split by priority, only with levels on
  assign p_hi_req = |(periph_req_one & pri1_q & pri1_mask) |
    |(periph_req_two & pri2_q) | |(periph_req_three & pri3_q);
  assign p_lo_req = |(periph_req_one & ~pri1_q & pri1_mask) |
    |(periph_req_two & ~pri2_q & `IPSRC_MSK_PRI2) |
    |(periph_req_three & ~pri3_q & `IPSRC_MSK_PRI3);
  always @*
  begin
    core_hi = |(pin_en & pin_fl & pin_pri);
    core_lo = |(pin_en & pin_fl & ~pin_pri);
    if (icon_q[`IPSRC_T0IE_BIT] && icon_q[`IPSRC_T0IF_BIT])
    begin
      if (icon2_q[`IPSRC_T0IP_BIT])
        core_hi = 1'b1;
      else
        core_lo = 1'b1;
    end
    if (icon_q[`IPSRC_PORT_CHANGE_ENABLE_BIT] && icon_q[`IPSRC_PORT_CHANGE_FLAG_BIT])
    begin
      if (icon2_q[`IPSRC_PORT_CHANGE_PRIORITY_BIT])
        core_hi = 1'b1;
      else
        core_lo = 1'b1;
    end
    per_hi = p_hi_req;
    per_lo = p_lo_req;
  end
  // register writes and hardware flag sets; interrupt flag sets win over writes, reset-cause updates are skipped on any write, clear wins over set
  always @(posedge core_clk)
  begin
    if (!rstn)
    begin
      pri1_q <= `IPSRC_RST_PRI1;
      pri2_q <= `IPSRC_RST_PRI2;
      pri3_q <= `IPSRC_RST_PRI3;
      reset_cause_and_priority_control_q <= `IPSRC_RST_RESET_CAUSE_AND_PRIORITY_CONTROL;
      icon_q <= `IPSRC_RST_ICON;
      icon2_q <= `IPSRC_RST_ICON2;
      icon3_q <= `IPSRC_RST_ICON3;
      tctl_q <= 8'h00;
      tmr0_q <= 16'h0000;
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
      pin_s3_q <= 3'h0;
      rb_s1_q <= 4'h0;
      rb_s2_q <= 4'h0;
      rb_s3_q <= 4'h0;
      rb_last_q <= 4'h0;
      pin_lvl_q <= 3'h0;
      rb_lvl_q <= 4'h0;
    end
    else
    begin
      pin_s1_q <= pin_irq;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_lvl_q <= (pin_s2_q & pin_s3_q) | (pin_lvl_q & (pin_s2_q ^ pin_s3_q));
      rb_s1_q <= port_b_pins;
      rb_s2_q <= rb_s1_q;
      rb_s3_q <= rb_s2_q;
      if (rb_s2_q == rb_s3_q)
        rb_lvl_q <= rb_s3_q;
      if (reg_rd && reg_addr == `IPSRC_A_ICON)
        rb_last_q <= rb_lvl_q;
      if (reg_wr)
      begin
        case (reg_addr)
          `IPSRC_A_PRI1: pri1_q <= reg_wdata & pri1_mask;
          `IPSRC_A_PRI2: pri2_q <= reg_wdata & `IPSRC_MSK_PRI2;
          `IPSRC_A_PRI3: pri3_q <= reg_wdata & `IPSRC_MSK_PRI3;
          `IPSRC_A_RESET_CAUSE_AND_PRIORITY_CONTROL: reset_cause_and_priority_control_q <= (reg_wdata & `IPSRC_MSK_RESET_CAUSE_AND_PRIORITY_CONTROL & ~`IPSRC_RO_RESET_CAUSE_AND_PRIORITY_CONTROL) |
            (reset_cause_and_priority_control_q & `IPSRC_RO_RESET_CAUSE_AND_PRIORITY_CONTROL);
          `IPSRC_A_ICON: icon_q <= reg_wdata;
          `IPSRC_A_ICON2: icon2_q <= reg_wdata & `IPSRC_MSK_ICON2;
          `IPSRC_A_ICON3: icon3_q <= reg_wdata & `IPSRC_MSK_ICON3;
          `IPSRC_A_TCTL: tctl_q <= reg_wdata;
          default: tctl_q <= tctl_q;
        endcase
      end
      else
      begin
        reset_cause_and_priority_control_q <= (reset_cause_and_priority_control_q | {2'b00, cause_set}) & ~{2'b00, cause_clr};
      end
      if (timer_tick)
        tmr0_q <= tctl_q[`IPSRC_T16_BIT] ? tmr0_q + 16'h0001 :
          {8'h00, tmr0_q[7:0] + 8'h01};
      if (edge_hit[0])
        icon_q[`IPSRC_P0IF_BIT] <= 1'b1;
      if (t0_roll)
        icon_q[`IPSRC_T0IF_BIT] <= 1'b1;
      if (rb_change)
        icon_q[`IPSRC_PORT_CHANGE_FLAG_BIT] <= 1'b1;
      if (edge_hit[1])
        icon3_q[`IPSRC_P1IF_BIT] <= 1'b1;
      if (edge_hit[2])
        icon3_q[`IPSRC_P2IF_BIT] <= 1'b1;
    end
  end
  // request arbitration, service level tracking, context save
  always @(posedge core_clk)
  begin
    if (!rstn)
    begin
      irq_high <= 1'b0;
      irq_low <= 1'b0;
      wake <= 1'b0;
      hsvc_q <= 1'b0;
      lsvc_q <= 1'b0;
      sp_q <= 5'h00;
      stack_top <= {PC_W{1'b0}};
      shadow_working <= {DATA_W{1'b0}};
      shadow_status <= {DATA_W{1'b0}};
      shadow_bank <= {DATA_W{1'b0}};
      reg_rdata <= 8'h00;
    end
    else
    begin
      wake <= sleeping && (|(pin_en & pin_fl));
      if (priority_levels_enable)
      begin
        irq_high <= global_interrupt_enable && !hsvc_q && (core_hi || per_hi);
        irq_low <= global_interrupt_enable && peripheral_interrupt_enable && !hsvc_q && !lsvc_q &&
          (core_lo || per_lo);
      end
      else
      begin
        irq_high <= global_interrupt_enable && !hsvc_q && (core_hi || core_lo ||
          (peripheral_interrupt_enable && (per_hi || per_lo)));
        irq_low <= 1'b0;
      end
      if (entry_ack && (irq_high || irq_low))
      begin
        if (irq_high)
          hsvc_q <= 1'b1;
        else
          lsvc_q <= 1'b1;
        if (sp_q < STK_DEPTH)
        begin
          stack_mem[sp_q] <= return_pc;
          sp_q <= sp_q + 5'h01;
        end
        stack_top <= return_pc;
        shadow_working <= working_register;
        shadow_status <= status_in;
        shadow_bank <= bank_select_register;
      end
      else if (fast_return)
      begin
        if (hsvc_q)
          hsvc_q <= 1'b0;
        else
          lsvc_q <= 1'b0;
        if (sp_q != 5'h00)
        begin
          sp_q <= sp_q - 5'h01;
          stack_top <= (sp_q > 5'h01) ? stack_mem[sp_q - 5'h02] : {PC_W{1'b0}};
        end
      end
      if (reg_rd)
      begin
        case (reg_addr)
          `IPSRC_A_PRI1: reg_rdata <= pri1_q & pri1_mask;
          `IPSRC_A_PRI2: reg_rdata <= pri2_q;
          `IPSRC_A_PRI3: reg_rdata <= pri3_q;
          `IPSRC_A_RESET_CAUSE_AND_PRIORITY_CONTROL: reg_rdata <= reset_cause_and_priority_control_q;
          `IPSRC_A_ICON: reg_rdata <= icon_q;
          `IPSRC_A_ICON2: reg_rdata <= icon2_q;
          `IPSRC_A_ICON3: reg_rdata <= icon3_q;
          default: reg_rdata <= tctl_q;
        endcase
      end
      else
        reg_rdata <= 8'h00;
    end
  end
endmodule
`default_nettype wire

//--- testbench/ipsrc_chk.sv
// port checker for the interrupt priority block
`timescale 1ns/10ps
`default_nettype none
module ipsrc_chk (
  // clock, reset, register port
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // core side
  input wire logic entry_ack,
  input wire logic [20:0] return_pc,
  input wire logic [7:0] working_register,
  input wire logic [7:0] status_in,
  input wire logic [7:0] bank_select_register,
  input wire logic irq_low,
  input wire logic [20:0] stack_top,
  input wire logic [7:0] shadow_working,
  input wire logic [7:0] shadow_status,
  input wire logic [7:0] shadow_bank
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  logic priority_levels_enable_q;
  // shadow copy of the priority enable
  always @(posedge core_clk)
    if (!rstn)
      priority_levels_enable_q <= 1'b0;
    else if (reg_wr && reg_addr == 3'h3)
      priority_levels_enable_q <= reg_wdata[7];
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_pri2_unused: assert property ($past(reg_rd) && $past(reg_addr) == 3'h1 |->
    (reg_rdata & 8'h36) == 8'h00) else $error("unused priority two bits read high");
  a_pri3_unused: assert property ($past(reg_rd) && $past(reg_addr) == 3'h2 |->
    (reg_rdata & 8'h3f) == 8'h00) else $error("unused priority three bits read high");
  a_reset_cause_and_priority_control_gap: assert property ($past(reg_rd) && $past(reg_addr) == 3'h3 |->
    !reg_rdata[6]) else $error("reset control bit 6 read high");
  a_pri1_back: assert property (reg_wr && reg_addr == 3'h0 ##1 reg_rd && reg_addr == 3'h0
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("priority one readback differs");
  a_stack_push: assert property (entry_ack |=> stack_top == $past(return_pc))
    else $error("return address not on stack");
  a_shadow_save: assert property (entry_ack |=> shadow_working == $past(working_register)
    && shadow_status == $past(status_in) && shadow_bank == $past(bank_select_register))
    else $error("shadow registers not saved");
  a_one_level: assert property ((!priority_levels_enable_q) [*3] |-> !irq_low)
    else $error("low request in single level mode");
endmodule
bind ipsrc_top ipsrc_chk u_chk (.core_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .entry_ack, .return_pc, .working_register, .status_in, .bank_select_register,
  .irq_low, .stack_top, .shadow_working, .shadow_status, .shadow_bank);
`default_nettype wire

//--- testbench/ipsrc_core_model.sv
// processor core partner taking interrupt entries
`timescale 1ns/10ps
`default_nettype none
module ipsrc_core_model (
  // clock, reset, control
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic irq_high,
  input wire logic take,
  // entry side
  output logic entry_ack,
  output logic [20:0] return_pc,
  output logic [7:0] working_register,
  output logic [7:0] status_in,
  output logic [7:0] bank_select_register
);
  assign working_register = 8'h5a;
  assign status_in = 8'h03;
  assign bank_select_register = 8'h0f;
  // one acknowledge per request, then the address moves on
  always @(posedge core_clk)
    if (!rstn)
    begin
      entry_ack <= 1'b0;
      return_pc <= 21'h0_0100;
    end
    else
    begin
      entry_ack <= take && irq_high && !entry_ack;
      if (entry_ack)
        return_pc <= return_pc + 21'h0_0004;
    end
endmodule
`default_nettype wire

//--- testbench/tb_interrupt_priority_and_sources.sv
// testbench for interrupt priority and sources
`timescale 1ns/10ps
`default_nettype none
`define IPSRC_CHK(a, e) begin total_checks++; if ((a) !== (e)) begin bad_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module tb_interrupt_priority_and_sources;
  logic core_clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, timer_tick = 0, sleeping = 0;
  logic take = 0, fast_return = 0, entry_ack, irq_high, irq_low, wake;
  logic [2:0] reg_addr = 0, pin_irq = 0;
  logic [7:4] port_b_pins = 0;
  logic [7:0] reg_wdata = 0, reg_rdata, periph_req_one = 0, periph_req_two = 0;
  logic [7:0] periph_req_three = 0, working_register, status_in, bank_select_register;
  logic [7:0] shadow_working, shadow_status, shadow_bank;
  logic [5:0] cause_set = 0, cause_clr = 0;
  logic [20:0] return_pc, stack_top;
  logic [7:0] rst_tab [8] = '{8'hff, 8'hc8, 8'hc0, 8'h3c, 8'h00, 8'hf5, 8'hc0, 8'h00};
  int bad_count = 0, total_checks = 0;
  ipsrc_top DUT (.core_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .pin_irq, .port_b_pins, .periph_req_one, .periph_req_two, .periph_req_three,
    .timer_tick, .cause_set, .cause_clr, .sleeping, .entry_ack, .fast_return, .return_pc,
    .working_register, .status_in, .bank_select_register, .irq_high, .irq_low, .wake,
    .stack_top, .shadow_working, .shadow_status, .shadow_bank);
  ipsrc_core_model u_core (.core_clk, .rstn, .irq_high, .take, .entry_ack, .return_pc,
    .working_register, .status_in, .bank_select_register);
  initial
  begin
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 `IPSRC_CHK(reg_rdata, e)
  endtask
  // write then read back with no gap
  task automatic wrrd(input logic [2:0] a, input logic [7:0] d, input logic [7:0] e);
    wr(a, d);
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 `IPSRC_CHK(reg_rdata, e)
  endtask
  task automatic ticks(input int n);
    @(posedge core_clk) timer_tick <= 1'b1;
    repeat (n) @(posedge core_clk);
    timer_tick <= 1'b0;
  endtask
  initial
  begin
    #(25 * 80000);
    bad_count++;
    stop_test();
  end
  initial
  begin
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 8; i++)
      rd(i[2:0], rst_tab[i]);
    wrrd(3'h0, 8'h00, 8'h00);
    wrrd(3'h1, 8'hff, 8'hc9);
    wrrd(3'h2, 8'hff, 8'hc0);
    wrrd(3'h3, 8'hff, 8'hbf);
    wrrd(3'h3, 8'h00, 8'h0c);
    $display("registers done");
    wr(3'h3, 8'h80);
    wr(3'h0, 8'hfe);
    wr(3'h4, 8'hc0);
    @(posedge core_clk) periph_req_one <= 8'h01;
    tick(4);
    `IPSRC_CHK({irq_high, irq_low}, 2'b01)
    wr(3'h0, 8'hff);
    tick(4);
    `IPSRC_CHK({irq_high, irq_low}, 2'b10)
    wr(3'h3, 8'h00);
    wr(3'h0, 8'hfe);
    tick(4);
    `IPSRC_CHK({irq_high, irq_low}, 2'b10)
    wr(3'h4, 8'h80);
    tick(4);
    `IPSRC_CHK({irq_high, irq_low}, 2'b00)
    @(posedge core_clk) periph_req_one <= 8'h00;
    $display("priority done");
    wr(3'h4, 8'h90);
    @(posedge core_clk) pin_irq <= 3'h1;
    tick(8);
    `IPSRC_CHK(irq_high, 1'b1)
    @(posedge core_clk) take <= 1'b1;
    @(posedge core_clk) take <= 1'b0;
    tick(3);
    `IPSRC_CHK({stack_top, shadow_working}, {21'h0_0100, 8'h5a})
    @(posedge core_clk) fast_return <= 1'b1;
    @(posedge core_clk) fast_return <= 1'b0;
    wr(3'h4, 8'h80);
    tick(3);
    `IPSRC_CHK(irq_high, 1'b0)
    wr(3'h5, 8'h75);
    wr(3'h4, 8'h10);
    @(posedge core_clk) sleeping <= 1'b1;
    pin_irq <= 3'h0;
    tick(8);
    `IPSRC_CHK({wake, irq_high}, 2'b10)
    rd(3'h4, 8'h12);
    @(posedge core_clk) sleeping <= 1'b0;
    port_b_pins <= 4'h2;
    tick(6);
    rd(3'h4, 8'h13);
    $display("pins done");
    for (int m = 1; m >= 0; m--)
    begin
      wr(3'h7, m[7:0]);
      wr(3'h4, 8'h00);
      ticks(m ? 65535 : 255);
      rd(3'h4, 8'h00);
      ticks(1);
      tick(3);
      rd(3'h4, 8'h04);
    end
    $display("timer done");
    stop_test();
  end
endmodule
`default_nettype wire
